// ==== rtl/scj_pkg.sv ====
package scj_pkg;

  // Data path width of one accumulator half
  localparam int unsigned WORD_W = 18;

  // Function codes (octal 02, 03, 06, 07, 50, 60..67)
  localparam logic [5:0] FN_CMP_Y = 6'h02;
  localparam logic [5:0] FN_CMP_YB = 6'h03;
  localparam logic [5:0] FN_CMP_MY = 6'h06;
  localparam logic [5:0] FN_CMP_MYB = 6'h07;
  localparam logic [5:0] FN_MISC = 6'h28;
  localparam logic [5:0] FN_JP_FIRST = 6'h30;
  localparam logic [5:0] FN_JP_LAST = 6'h37;

  // Sub codes of the miscellaneous group (octal 53..77)
  localparam logic [5:0] SC_SKIP_NO_OVF = 6'h2b;
  localparam logic [5:0] SC_SKIP_ODD = 6'h2c;
  localparam logic [5:0] SC_SKIP_EVEN = 6'h2d;
  localparam logic [5:0] SC_STOP_KEY = 6'h2e;
  localparam logic [5:0] SC_SKIP_NO_RESUME = 6'h2f;
  localparam logic [5:0] SC_ROUND = 6'h30;
  localparam logic [5:0] SC_INV_LOWER = 6'h31;
  localparam logic [5:0] SC_INV_UPPER = 6'h32;
  localparam logic [5:0] SC_INV_ACC = 6'h33;
  localparam logic [5:0] SC_LOAD_ICR = 6'h3a;
  localparam logic [5:0] SC_LOAD_SR = 6'h3b;
  localparam logic [5:0] SC_ILLEGAL = 6'h3f;

  // Field positions inside k and widths of loaded registers
  localparam int unsigned K_UNCOND_BIT = 5;
  localparam int unsigned ICR_W = 3;
  localparam int unsigned SR_W = 5;
  localparam int unsigned SR_ACTIVE_BIT = 3;
  localparam int unsigned STOP_KEYS = 5;
  localparam int unsigned CHANNELS = 16;

  // Instruction time and its clock count
  localparam int unsigned INSTR_TIME_NS = 2000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INSTR_CYC = INSTR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  // Register map (byte addresses) and field positions
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_KEYS = 4'h8;
  localparam int unsigned ST_DESIG_LSB = 0;
  localparam int unsigned ST_OVF_BIT = 3;
  localparam int unsigned ST_HALT_BIT = 4;
  localparam int unsigned ST_BUSY_BIT = 5;
  localparam int unsigned ST_ICR_LSB = 8;
  localparam int unsigned ST_SR_LSB = 12;
  localparam int unsigned CTRL_RELEASE_BIT = 0;
  localparam int unsigned CTRL_CLR_OVF_BIT = 1;
  localparam logic [4:0] KEYS_RESET = 5'h00;

  typedef struct packed {
    logic [5:0] func;
    logic [5:0] sub;
    logic [5:0] k;
    logic [17:0] operand;
  } scj_instr_t;

  typedef struct packed {
    logic [17:0] au;
    logic [17:0] al;
    logic au_wr;
    logic al_wr;
    logic skip;
    logic jump;
    logic halt;
    logic illegal;
  } scj_result_t;

  // Comparison designator: compare, less than, equals
  typedef struct packed {
    logic cmp;
    logic lt;
    logic eq;
  } scj_desig_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_HALT = 2'b10
  } scj_state_t;

endpackage

// ==== rtl/scj_eval.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operand evaluation: optionally masked compare in ones' complement order and masked parity
module scj_eval
  import scj_pkg::*;
(
  // Operands
  input wire logic [17:0] au_in,
  input wire logic [17:0] al_in,
  input wire logic [17:0] mem_in,
  input wire logic mask_in,
  // Results
  output logic lt_out,
  output logic eq_out,
  output logic odd_out
);

  // Ones' complement order: a negative value is below any positive one,
  // within one sign the raw bit order holds
  function automatic logic oc_less(input logic [17:0] a, input logic [17:0] b);
    if (a[17] != b[17])
      oc_less = a[17];
    else
      oc_less = a < b;
  endfunction

  logic [17:0] lhs;
  logic [17:0] rhs;

  // Mask both sides with the upper half for the masked compares
  always_comb
  begin
    lhs = mask_in ? (al_in & au_in) : al_in;
    rhs = mask_in ? (mem_in & au_in) : mem_in;
    lt_out = oc_less(lhs, rhs);
    eq_out = lhs == rhs;
    odd_out = ^(al_in & au_in);
  end

endmodule // scj_eval
`default_nettype wire

// ==== rtl/scj_exec.sv ====
// Operation
// - No-overflow skip: skip if flag clear, always clear flag, ignore k; a new overflow in the final cycle keeps the flag set.
// - Odd parity skip: AND halves, skip when ones count is odd.
// - Even parity skip: skip when ones count of AND is even.
// - Stop when a k bit 0-4 matches a set stop key, or k bit 5.
// - Skip when resume flag of output channel k is clear.
// - Round: upper plus/minus lower bit 17 into lower half.
// - Invert lower half, but all zeros stays all zeros.
// - Invert upper half or whole accumulator, same zero exception, ignore k.
// - Codes 64-71 and 74-76 unused; 77 is illegal, one instruction time.
// - Load index control register with k bits 2..0 after clearing.
// - Load special register with k bits 4..0; bit 3 activates it.
// - Every skip takes the same instruction time, taken or not.
// - Any compare sets the compare stage of the designator.
// - Compare sets less-than when (masked) lower half is below operand.
// - Compare sets equals when (masked) lower half equals operand.
// - Any instruction except compares and jumps 60-67 clears the designator.
// - Codes 06/07 mask lower half and memory word with upper half.
// - Jumps 60/61 on zero half, or on equals when designator set.
// - Jumps 62/63 on nonzero half, or on not-equals when set.
// - Jumps 64/65 on positive half, or on not-less when set.
// - Jumps 66/67 on negative half, or on less-than when set.
// - Jump not taken or not applicable: go to next address.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module scj_exec
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Instruction issue with accumulator contents
  input wire logic instr_valid_in,
  input wire scj_pkg::scj_instr_t instr_in,
  input wire logic [17:0] au_in,
  input wire logic [17:0] al_in,
  output logic instr_ready_out,
  // Machine state inputs
  input wire logic overflow_set_in,
  input wire logic [15:0] resume_in,
  // Completion
  output logic done_out,
  output scj_pkg::scj_result_t result_out,
  output logic [1:0] pc_step_out,
  // Loaded registers and status
  output logic [2:0] index_control_out,
  output logic [4:0] special_reg_out,
  output logic sr_active_out,
  output logic halted_out
);
  import scj_pkg::*;

  scj_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  scj_instr_t instr_q;
  logic [17:0] au_q, al_q;
  scj_desig_t desig_q;
  logic ovf_q;
  logic [STOP_KEYS-1:0] keys_q;
  logic [ICR_W-1:0] icr_q;
  logic [SR_W-1:0] sr_q;
  logic ready_q, done_q;
  scj_result_t result_q;
  scj_result_t res_d;
  logic [1:0] pc_step_q;
  logic [31:0] rdata_q;
  logic finish, is_misc, is_cmp, is_jump;
  logic cmp_lt, cmp_eq, par_odd, jump_cond, ctrl_wr;

  // Whole-word invert that leaves positive zero untouched
  function automatic logic [17:0] inv_keep_zero(input logic [17:0] v);
    inv_keep_zero = (v == 18'h00000) ? v : ~v;
  endfunction

  // Decoding of the function code, used by several processes
  function automatic logic is_compare(input logic [5:0] f);
    is_compare = (f == FN_CMP_Y) || (f == FN_CMP_YB)
                 || (f == FN_CMP_MY) || (f == FN_CMP_MYB);
  endfunction

  assign finish = (state_q == ST_EXEC) && (cnt_q == '0);
  assign is_misc = instr_q.func == FN_MISC;
  assign is_cmp = is_compare(instr_q.func);
  assign is_jump = (instr_q.func >= FN_JP_FIRST)
                   && (instr_q.func <= FN_JP_LAST);
  assign ctrl_wr = reg_wr_in && (reg_addr_in == REG_CTRL);

  // Compare and parity evaluation on the latched operands
  scj_eval u_eval
  (
    .au_in(au_q),
    .al_in(al_q),
    .mem_in(instr_q.operand),
    .mask_in(instr_q.func[2]),
    .lt_out(cmp_lt),
    .eq_out(cmp_eq),
    .odd_out(par_odd)
  );

  // Jump condition: low bit picks the half, upper bits pick the test
  always_comb
  begin
    logic [17:0] half;
    half = instr_q.func[0] ? al_q : au_q;
    jump_cond = 1'b0;
    case (instr_q.func[2:1])
      2'b00:
        jump_cond = desig_q.cmp ? desig_q.eq : (half == 18'h00000);
      2'b01:
        jump_cond = desig_q.cmp ? !desig_q.eq : (half != 18'h00000);
      2'b10:
        jump_cond = desig_q.cmp ? !desig_q.lt : !half[17];
      2'b11:
        jump_cond = desig_q.cmp ? desig_q.lt : half[17];
      default:
        jump_cond = 1'b0;
    endcase
  end

  // Result of the latched instruction, valid in its final cycle
  always_comb
  begin
    res_d = '0;
    res_d.au = au_q;
    res_d.al = al_q;
    if (is_jump)
      res_d.jump = jump_cond;
    else if (is_misc)
    begin
      case (instr_q.sub)
        SC_SKIP_NO_OVF:
          res_d.skip = !ovf_q;
        SC_SKIP_ODD:
          res_d.skip = par_odd;
        SC_SKIP_EVEN:
          res_d.skip = !par_odd;
        SC_STOP_KEY:
          res_d.halt = |(instr_q.k[STOP_KEYS-1:0] & keys_q)
                       || instr_q.k[K_UNCOND_BIT];
        SC_SKIP_NO_RESUME:
          res_d.skip = !resume_in[instr_q.k[3:0]];
        SC_ROUND:
        begin
          res_d.al_wr = 1'b1;
          if (!au_q[17])
            res_d.al = au_q + {17'h00000, al_q[17]};
          else
            res_d.al = au_q - {17'h00000, !al_q[17]};
        end
        SC_INV_LOWER:
        begin
          res_d.al_wr = 1'b1;
          res_d.al = inv_keep_zero(al_q);
        end
        SC_INV_UPPER:
        begin
          res_d.au_wr = 1'b1;
          res_d.au = inv_keep_zero(au_q);
        end
        SC_INV_ACC:
        begin
          res_d.au_wr = 1'b1;
          res_d.al_wr = 1'b1;
          if ({au_q, al_q} != 36'h000000000)
          begin
            res_d.au = ~au_q;
            res_d.al = ~al_q;
          end
        end
        SC_ILLEGAL:
          res_d.illegal = 1'b1;
        default:
          // Unused codes and group members handled elsewhere do nothing
          res_d.skip = 1'b0;
      endcase
    end
  end

  // Sequencer: every instruction takes the full instruction time
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (instr_valid_in)
          state_d = ST_EXEC;
      ST_EXEC:
        if (cnt_q == '0)
          state_d = res_d.halt ? ST_HALT : ST_IDLE;
      ST_HALT:
        if (ctrl_wr && reg_wdata_in[CTRL_RELEASE_BIT])
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Cycle counter; taken and untaken skips share one fixed length
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      cnt_q <= '0;
    else if ((state_q == ST_IDLE) && instr_valid_in)
      cnt_q <= CNT_W'(INSTR_CYC - 1);
    else if ((state_q == ST_EXEC) && (cnt_q != '0))
      cnt_q <= cnt_q - 1'b1;
  end

  // Instruction and operands are held for the whole execution
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      instr_q <= '0;
      au_q <= '0;
      al_q <= '0;
    end
    else if ((state_q == ST_IDLE) && instr_valid_in)
    begin
      instr_q <= instr_in;
      au_q <= au_in;
      al_q <= al_in;
    end
  end

  // Comparison designator survives only a run of conditional jumps
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      desig_q <= '0;
    else if (finish)
    begin
      if (is_cmp)
      begin
        desig_q.cmp <= 1'b1;
        desig_q.lt <= cmp_lt;
        desig_q.eq <= cmp_eq;
      end
      else if (!is_jump)
        desig_q <= '0;
    end
  end

  // Overflow flag; a new overflow wins over a clear in the same cycle
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      ovf_q <= 1'b0;
    else if (overflow_set_in)
      ovf_q <= 1'b1;
    else if (finish && is_misc && (instr_q.sub == SC_SKIP_NO_OVF))
      ovf_q <= 1'b0;
    else if (ctrl_wr && reg_wdata_in[CTRL_CLR_OVF_BIT])
      ovf_q <= 1'b0;
  end

  // Index control and special registers are replaced whole
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      icr_q <= '0;
      sr_q <= '0;
    end
    else if (finish && is_misc)
    begin
      if (instr_q.sub == SC_LOAD_ICR)
        icr_q <= instr_q.k[ICR_W-1:0];
      if (instr_q.sub == SC_LOAD_SR)
        sr_q <= instr_q.k[SR_W-1:0];
    end
  end

  // Console stop keys are held in a software register
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      keys_q <= KEYS_RESET;
    else if (reg_wr_in && (reg_addr_in == REG_KEYS))
      keys_q <= reg_wdata_in[STOP_KEYS-1:0];
  end

  // Completion outputs; a skip steps the address by two words
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      done_q <= 1'b0;
      result_q <= '0;
      pc_step_q <= 2'h1;
    end
    else
    begin
      done_q <= finish;
      if (finish)
      begin
        result_q <= res_d;
        pc_step_q <= res_d.skip ? 2'h2 : 2'h1;
      end
    end
  end

  // Ready follows the next state so it never offers while busy
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      ready_q <= 1'b0;
    else
      ready_q <= (state_d == ST_IDLE);
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      rdata_q <= '0;
    else if (reg_rd_in)
    begin
      rdata_q <= '0;
      case (reg_addr_in)
        REG_STATUS:
        begin
          rdata_q[ST_DESIG_LSB +: 3] <= desig_q;
          rdata_q[ST_OVF_BIT] <= ovf_q;
          rdata_q[ST_HALT_BIT] <= state_q == ST_HALT;
          rdata_q[ST_BUSY_BIT] <= state_q == ST_EXEC;
          rdata_q[ST_ICR_LSB +: ICR_W] <= icr_q;
          rdata_q[ST_SR_LSB +: SR_W] <= sr_q;
        end
        REG_KEYS:
          rdata_q[STOP_KEYS-1:0] <= keys_q;
        default:
          rdata_q <= '0;
      endcase
    end
    else
      rdata_q <= '0;
  end

  assign reg_rdata_out = rdata_q;
  assign instr_ready_out = ready_q;
  assign done_out = done_q;
  assign result_out = result_q;
  assign pc_step_out = pc_step_q;
  assign index_control_out = icr_q;
  assign special_reg_out = sr_q;
  assign sr_active_out = sr_q[SR_ACTIVE_BIT];
  assign halted_out = state_q[1]; // Only the halt code has bit 1 set

endmodule // scj_exec
`default_nettype wire

// ==== tb/scj_exec_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module scj_exec_asserts
  import scj_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Watched ports
  input wire logic instr_valid_in,
  input wire logic instr_ready_out,
  input wire logic done_out,
  input wire scj_pkg::scj_result_t result_out,
  input wire logic [1:0] pc_step_out,
  input wire logic [4:0] special_reg_out,
  input wire logic sr_active_out,
  input wire logic halted_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // Step expected from the skip flag, kept apart to keep lines short
  logic [1:0] step_exp;
  assign step_exp = result_out.skip ? 2'h2 : 2'h1;

  // Issue edge, then a fixed wait of 201 edges for completion
  sequence s_take;
    instr_valid_in && instr_ready_out;
  endsequence
  sequence s_finish;
    ##1 !done_out [*8] ##193 done_out;
  endsequence

  instr_time_a: assert property (s_take |-> s_finish)
    else $error("completion not 201 cycles after issue");
  busy_hold_a: assert property (s_take |=> !instr_ready_out [*8])
    else $error("ready high while executing");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("completion pulse longer than one cycle");
  skip_step_a: assert property (done_out |-> pc_step_out == step_exp)
    else $error("program step does not match skip");
  jump_step_a: assert property
    (done_out && result_out.jump |-> pc_step_out == 2'h1)
    else $error("jump result with a skip step");
  result_hold_a: assert property
    (!done_out |-> $stable({result_out, pc_step_out}))
    else $error("result changed between completions");
  halt_stop_a: assert property (done_out && result_out.halt |-> halted_out)
    else $error("stop result without halted state");
  halt_ready_a: assert property (halted_out |-> !instr_ready_out)
    else $error("ready while halted");
  special_on_a: assert property
    (!done_out |-> $stable({sr_active_out, special_reg_out}))
    else $error("special register changed outside an instruction end");
  illegal_quiet_a: assert property
    (done_out && result_out.illegal |-> !(result_out.skip || result_out.jump))
    else $error("illegal code skipped or jumped");
endmodule // scj_exec_asserts
`default_nettype wire

// ==== tb/skip_compare_jump_logic_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      n_mismatch++; \
      $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module skip_compare_jump_logic_test;
  import scj_pkg::*;
  // Bench drives and design outputs
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic iv = 1'h0;
  scj_instr_t ins = 36'h0;
  logic [17:0] hi = 18'h0;
  logic [17:0] lo = 18'h0;
  logic ovf = 1'h0;
  logic [15:0] resm = 16'h0;
  logic [31:0] rdat, d;
  logic rdy, done, spec_on, hlt;
  scj_result_t r;
  logic [1:0] step;
  logic [2:0] idx_ctl;
  logic [4:0] spec;
  int checks = 0;
  int n_mismatch = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  scj_exec dut
  (
    .core_clk_in(clk),
    .rst_in(rst),
    .reg_addr_in(addr),
    .reg_wdata_in(wdat),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_rdata_out(rdat),
    .instr_valid_in(iv),
    .instr_in(ins),
    .au_in(hi),
    .al_in(lo),
    .instr_ready_out(rdy),
    .overflow_set_in(ovf),
    .resume_in(resm),
    .done_out(done),
    .result_out(r),
    .pc_step_out(step),
    .index_control_out(idx_ctl),
    .special_reg_out(spec),
    .sr_active_out(spec_on),
    .halted_out(hlt)
  );

  // Closing report, also reached when a wait runs out
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tmo();
    n_mismatch++;
    $display("[ERR] t=%0t wait got %h exp %h", $time, 1'h0, 1'h1);
    print_verdict();
  endtask

  // Register port: one-cycle strobes, read data the cycle after
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdat <= v;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    d = rdat;
  endtask

  // Issue once ready, hold valid for the taking edge, wait for done
  task automatic issue(input logic [5:0] f, s, k,
                       input logic [17:0] op, u, l);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'h1)
    begin
      n++;
      if (n > 400)
        tmo();
      @(negedge clk);
    end
    @(posedge clk);
    iv <= 1'h1;
    ins <= '{f, s, k, op};
    hi <= u;
    lo <= l;
    @(posedge clk);
    iv <= 1'h0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n > 400)
        tmo();
    end
    while (done !== 1'h1);
  endtask

  task automatic misc(input logic [5:0] s, k, input logic [17:0] u, l);
    issue(FN_MISC, s, k, 18'h0, u, l);
  endtask

  task automatic t_skips();
    @(posedge clk);
    ovf <= 1'h1;
    resm <= 16'h0004;
    @(posedge clk);
    ovf <= 1'h0;
    reg_rd(4'hc);
    `CHK(d, 32'h0)
    reg_rd(REG_STATUS);
    `CHK(d[ST_OVF_BIT], 1'h1)
    for (int i = 0; i < 2; i++)
    begin
      misc(SC_SKIP_NO_OVF, 6'h3f, 18'h0, 18'h0);
      `CHK({r.skip, step}, i ? 3'h6 : 3'h1)
      misc(SC_SKIP_NO_RESUME, 6'h02 + 6'(i), 18'h0, 18'h0);
      `CHK({r.skip, step}, i ? 3'h6 : 3'h1)
    end
    // Odd-count mask first, even-count mask second
    for (int i = 0; i < 4; i++)
    begin
      misc(i[0] ? SC_SKIP_EVEN : SC_SKIP_ODD, 6'h00,
           i[1] ? 18'h00003 : 18'h0003f, i[1] ? 18'h3ffff : 18'h2afd3);
      `CHK({r.skip, r.au_wr, r.al_wr}, {i[0] ~^ i[1], 2'h0})
    end
    // Software clear of the overflow flag through the control register
    @(posedge clk);
    ovf <= 1'h1;
    @(posedge clk);
    ovf <= 1'h0;
    reg_wr(REG_CTRL, 32'h2);
    reg_rd(REG_STATUS);
    `CHK(d[ST_OVF_BIT], 1'h0)
    $display("skip test done");
  endtask

  task automatic t_stop();
    reg_wr(REG_KEYS, 32'h2);
    reg_rd(REG_KEYS);
    `CHK(d[4:0], 5'h02)
    misc(SC_STOP_KEY, 6'h1d, 18'h0, 18'h0);
    `CHK({r.halt, hlt}, 2'h0)
    misc(SC_STOP_KEY, 6'h02, 18'h0, 18'h0);
    `CHK({r.halt, hlt}, 2'h3)
    reg_wr(REG_CTRL, 32'h1);
    reg_wr(REG_KEYS, 32'h0);
    misc(SC_STOP_KEY, 6'h20, 18'h0, 18'h0);
    `CHK({r.halt, hlt}, 2'h3)
    reg_wr(REG_CTRL, 32'h1);
    $display("stop test done");
  endtask

  task automatic t_arith();
    misc(SC_ROUND, 6'h3f, 18'h00100, 18'h20000);
    `CHK({r.al_wr, r.au_wr, r.al}, {2'h2, 18'h00101})
    misc(SC_ROUND, 6'h00, 18'h3ff00, 18'h00000);
    `CHK({r.al_wr, r.au_wr, r.al}, {2'h2, 18'h3feff})
    misc(SC_INV_LOWER, 6'h3f, 18'h00001, 18'h12345);
    `CHK({r.al_wr, r.au_wr, r.al}, {2'h2, 18'h2dcba})
    misc(SC_INV_LOWER, 6'h00, 18'h00001, 18'h0);
    `CHK(r.al, 18'h0)
    misc(SC_INV_UPPER, 6'h3f, 18'h0f0f0, 18'h0);
    `CHK({r.au_wr, r.al_wr, r.au}, {2'h2, 18'h30f0f})
    misc(SC_INV_ACC, 6'h3f, 18'h0, 18'h00001);
    `CHK({r.au, r.al}, {18'h3ffff, 18'h3fffe})
    misc(SC_INV_ACC, 6'h00, 18'h0, 18'h0);
    `CHK({r.au, r.al}, 36'h0)
    $display("arithmetic test done");
  endtask

  task automatic t_codes();
    logic [5:0] s;
    for (int i = 0; i < 10; i++)
    begin
      s = (i < 6) ? 6'h34 + 6'(i) : 6'h36 + 6'(i);
      misc(s, 6'h3f, 18'h0, 18'h0);
      `CHK({r.illegal, r.skip, r.halt, step}, {s == SC_ILLEGAL, 4'h1})
    end
    misc(SC_LOAD_ICR, 6'h3d, 18'h0, 18'h0);
    `CHK(idx_ctl, 3'h5)
    misc(SC_LOAD_ICR, 6'h02, 18'h0, 18'h0);
    `CHK(idx_ctl, 3'h2)
    misc(SC_LOAD_SR, 6'h3f, 18'h0, 18'h0);
    `CHK({spec_on, spec}, 6'h3f)
    misc(SC_LOAD_SR, 6'h17, 18'h0, 18'h0);
    `CHK({spec_on, spec}, 6'h17)
    $display("code table test done");
  endtask

  // Jumps with a clear designator, then after compares
  task automatic t_jumps();
    logic [7:0] e;
    for (int j = 0; j < 2; j++)
    begin
      e = j ? 8'h6c : 8'h99;
      for (int i = 0; i < 8; i++)
      begin
        issue(FN_JP_FIRST + 6'(i), 6'h00, 6'h00, 18'h0,
              j ? 18'h3fff0 : 18'h0, j ? 18'h00005 : 18'h20000);
        `CHK({r.jump, step}, {e[i], 2'h1})
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      issue({3'h0, i[1], 1'h1, i[0]}, 6'h00, 6'h00, 18'h00046, 18'h000ff,
            18'h12345);
      reg_rd(REG_STATUS);
      `CHK(d[2:0], {1'h1, i[1], 1'h0})
    end
    for (int i = 0; i < 4; i++)
    begin
      issue(FN_JP_FIRST + 6'(2 * i), 6'h00, 6'h00, 18'h0, 18'h0, 18'h00005);
      `CHK({r.jump, step}, {i[0], 2'h1})
    end
    reg_rd(REG_STATUS);
    `CHK(d[2:0], 3'h6)
    misc(6'h34, 6'h00, 18'h0, 18'h0);
    reg_rd(REG_STATUS);
    `CHK(d[2:0], 3'h0)
    issue(FN_CMP_Y, 6'h00, 6'h00, 18'h00046, 18'h0, 18'h00046);
    reg_rd(REG_STATUS);
    `CHK(d[2:0], 3'h5)
    for (int i = 0; i < 4; i++)
    begin
      issue(FN_JP_FIRST + 6'(2 * i + 1), 6'h00, 6'h00, 18'h0, 18'h0,
            18'h00046);
      `CHK({r.jump, step}, {~i[0], 2'h1})
    end
    $display("compare and jump test done");
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_skips();
    t_stop();
    t_arith();
    t_codes();
    t_jumps();
    print_verdict();
  end
endmodule // skip_compare_jump_logic_test

bind scj_exec scj_exec_asserts u_chk
(
  .core_clk_in,
  .rst_in,
  .instr_valid_in,
  .instr_ready_out,
  .done_out,
  .result_out,
  .pc_step_out,
  .special_reg_out,
  .sr_active_out,
  .halted_out
);
`default_nettype wire
